//--- inc/ush_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ush_link_if;
  logic                 tok_valid;
  ush_pkg::ush_tok_t    tok_pid;
  logic                 tok_last;
  logic                 rsp_valid;
  ush_pkg::ush_rsp_t    rsp_pid;
  logic [7:0]           rsp_data;
  logic                 rsp_last;

  modport dev
  (
    input  tok_valid,
    input  tok_pid,
    input  tok_last,
    output rsp_valid,
    output rsp_pid,
    output rsp_data,
    output rsp_last
  );

  modport host
  (
    output tok_valid,
    output tok_pid,
    output tok_last,
    input  rsp_valid,
    input  rsp_pid,
    input  rsp_data,
    input  rsp_last
  );
endinterface : ush_link_if
`default_nettype wire

//--- inc/ush_pkg.sv
`default_nettype none
package ush_pkg;

  // Token identifiers carried on the link
  typedef enum logic [1:0] {
    USH_TOK_NONE  = 2'b00,
    USH_TOK_SETUP = 2'b01,
    USH_TOK_IN    = 2'b10,
    USH_TOK_OUT   = 2'b11
  } ush_tok_t;

  // Answer identifiers from the device
  typedef enum logic [1:0] {
    USH_RSP_NONE = 2'b00,
    USH_RSP_NAK  = 2'b01,
    USH_RSP_DATA = 2'b10
  } ush_rsp_t;

  localparam int CLK_PERIOD_NS = 40;
  // One CRC bit on the wire
  localparam int CRC_BIT_NS    = 83;
  // Longest time, so rounded down; never below one cycle
  localparam int CRC_BIT_CYC   = (CRC_BIT_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                 (CRC_BIT_NS / CLK_PERIOD_NS);
  localparam int TOK_HDR_CYC   = 16;
  localparam int TOK_CRC_BITS  = 5;
  localparam int TOK_CYC       = TOK_HDR_CYC + TOK_CRC_BITS * CRC_BIT_CYC;
  localparam int DATA_LEN      = 8;
  localparam int RSP_TIMEOUT   = 16;
  localparam logic [7:0] DATA_RESET = 8'h00;

endpackage : ush_pkg
`default_nettype wire

//--- rtl/ush_dev.sv
`timescale 1ns/10ps
`default_nettype none
module ush_dev
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  ush_link_if.dev         link,
  input  wire logic       bus_module_enable,
  input  wire logic       flag_clear,
  input  wire logic [7:0] in_data,
  output logic            setup_received_flag,
  output logic            irq,
  output logic            tx_busy
);

  typedef enum logic [1:0] {
    USH_D_IDLE  = 2'b00,
    USH_D_TOKEN = 2'b01,
    USH_D_NAK   = 2'b10,
    USH_D_DATA  = 2'b11
  } ush_dstate_t;

  ush_dstate_t       state_reg;
  ush_dstate_t       state_next;
  ush_pkg::ush_tok_t pid_reg;
  logic [3:0]        cnt_reg;
  logic [7:0]        data_reg;
  logic              run;
  // Decoded link events and the slot outputs before the cap
  logic              tok_start;
  logic              tok_end;
  logic              setup_end;
  logic              slot_data;
  logic              data_end;
  logic              rsp_valid_c;
  logic              rsp_last_c;
  ush_pkg::ush_rsp_t rsp_pid_c;
  logic [3:0]        air_cnt_reg;
  logic              air_full;
  wire logic [7:0]   lane_data;

  // Module held in reset while disabled
  // low enable resets module
  assign run = rst_n && bus_module_enable;

  // A last cycle seen straight from idle is a one-cycle token and is
  // refused; pid_reg would still hold the type of the token before,
  // and a stale SETUP would raise the flag a second time
  assign tok_start = link.tok_valid && (state_reg == USH_D_IDLE);
  assign tok_end   = link.tok_valid && link.tok_last &&
                     (state_reg == USH_D_TOKEN);
  assign setup_end = tok_end && (pid_reg == ush_pkg::USH_TOK_SETUP);
  assign slot_data = (state_reg == USH_D_DATA);
  assign data_end  = slot_data &&
                     (cnt_reg == 4'(ush_pkg::DATA_LEN - 1));

  always_ff @(posedge clk_sys)
  begin
    if (!run)
      setup_received_flag <= 1'b0;
    else if (setup_end)
      setup_received_flag <= 1'b1;
    else if (flag_clear)
      setup_received_flag <= 1'b0;
  end

  assign irq = setup_received_flag;

  // Token type captured on its first cycle
  always_ff @(posedge clk_sys)
  begin
    if (!run)
      pid_reg <= ush_pkg::USH_TOK_NONE;
    else if (tok_start)
      pid_reg <= link.tok_pid;
  end

  // Decision is taken once, at the token's last bit, from the
  // registered flag; a clear landing mid-CRC only moves the answer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      USH_D_IDLE:
        if (link.tok_valid)
          state_next = link.tok_last ? USH_D_IDLE : USH_D_TOKEN;
      USH_D_TOKEN:
        if (!link.tok_valid)
          state_next = USH_D_IDLE;
        else if (link.tok_last)
        begin
          if (pid_reg != ush_pkg::USH_TOK_IN)
            state_next = USH_D_IDLE;
          else if (setup_received_flag)
            state_next = USH_D_NAK;
          else
            state_next = USH_D_DATA;
        end
      USH_D_NAK:
        state_next = USH_D_IDLE;
      USH_D_DATA:
        if (data_end)
          state_next = USH_D_IDLE;
      default:
        state_next = USH_D_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    // Cap closes the slot as well
    if (!run || air_full)
      state_reg <= USH_D_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!run || state_reg != USH_D_DATA)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_reg + 4'h1;
  end

  // Byte sampled each data cycle so software may stream it
  always_ff @(posedge clk_sys)
  begin
    if (!run)
      data_reg <= ush_pkg::DATA_RESET;
    else if (state_next == USH_D_DATA)
      data_reg <= in_data;
  end

  always_comb
  begin
    rsp_valid_c = 1'b0;
    rsp_last_c  = 1'b0;
    rsp_pid_c   = ush_pkg::USH_RSP_NONE;
    case (state_reg)
      USH_D_NAK:
      begin
        rsp_valid_c = 1'b1;
        rsp_last_c  = 1'b1;
        rsp_pid_c   = ush_pkg::USH_RSP_NAK;
      end
      USH_D_DATA:
      begin
        rsp_valid_c = 1'b1;
        rsp_last_c  = data_end;
        rsp_pid_c   = ush_pkg::USH_RSP_DATA;
      end
      default:
      begin
        rsp_valid_c = 1'b0;
        rsp_last_c  = 1'b0;
        rsp_pid_c   = ush_pkg::USH_RSP_NONE;
      end
    endcase
  end

  // air-time cap
  // Independent of the state coding, so a slip there still cannot
  // become an endless transmit; costs one small counter
  always_ff @(posedge clk_sys)
  begin
    if (!run || !rsp_valid_c)
      air_cnt_reg <= 4'h0;
    else if (!air_full)
      air_cnt_reg <= air_cnt_reg + 4'h1;
  end

  assign air_full = (air_cnt_reg == 4'(ush_pkg::DATA_LEN));

  // Lanes held low outside the data slot, so no stale byte shows
  genvar lane;
  generate
    for (lane = 0; lane < 8; lane = lane + 1)
    begin : g_lane
      assign lane_data[lane] = slot_data && data_reg[lane];
    end
  endgenerate

  assign link.rsp_valid = rsp_valid_c && !air_full;
  assign link.rsp_pid   = air_full ? ush_pkg::USH_RSP_NONE : rsp_pid_c;
  assign link.rsp_data  = lane_data;
  assign link.rsp_last  = rsp_last_c && !air_full;
  assign tx_busy        = link.rsp_valid;

endmodule : ush_dev
`default_nettype wire

//--- rtl/ush_host.sv
`timescale 1ns/10ps
`default_nettype none
module ush_host
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  ush_link_if.host        link,
  input  wire logic       send_setup,
  input  wire logic       send_in,
  output logic            ready,
  output logic            done,
  output logic            got_nak,
  output logic [3:0]      byte_cnt,
  output logic [7:0]      last_byte,
  input  wire logic       sw_clear_req,
  input  wire logic       guard_en,
  output logic            sw_flag_clear,
  output logic            sw_module_enable
);

  typedef enum logic [1:0] {
    USH_H_IDLE = 2'b00,
    USH_H_TOK  = 2'b01,
    USH_H_WAIT = 2'b10,
    USH_H_RX   = 2'b11
  } ush_hstate_t;

  typedef enum logic [1:0] {
    USH_S_IDLE   = 2'b00,
    USH_S_CLEAR  = 2'b01,
    USH_S_ENABLE = 2'b10
  } ush_sstate_t;

  ush_hstate_t       hst_reg;
  ush_pkg::ush_tok_t pid_reg;
  logic [5:0]        cnt_reg;
  ush_sstate_t       sst_reg;

  assign ready = (hst_reg == USH_H_IDLE);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      hst_reg <= USH_H_IDLE;
      pid_reg <= ush_pkg::USH_TOK_NONE;
      cnt_reg <= 6'h00;
    end
    else
    begin
      case (hst_reg)
        USH_H_IDLE:
          if (send_setup || send_in)
          begin
            hst_reg <= USH_H_TOK;
            pid_reg <= send_setup ? ush_pkg::USH_TOK_SETUP :
                                    ush_pkg::USH_TOK_IN;
            cnt_reg <= 6'h00;
          end
        USH_H_TOK:
          if (cnt_reg == 6'(ush_pkg::TOK_CYC - 1))
          begin
            cnt_reg <= 6'h00;
            hst_reg <= (pid_reg == ush_pkg::USH_TOK_IN) ? USH_H_WAIT :
                                                          USH_H_IDLE;
          end
          else
            cnt_reg <= cnt_reg + 6'h01;
        USH_H_WAIT:
          if (link.rsp_valid)
            hst_reg <= link.rsp_last ? USH_H_IDLE : USH_H_RX;
          else if (cnt_reg == 6'(ush_pkg::RSP_TIMEOUT - 1))
            hst_reg <= USH_H_IDLE;
          else
            cnt_reg <= cnt_reg + 6'h01;
        USH_H_RX:
          if (!link.rsp_valid || link.rsp_last)
            hst_reg <= USH_H_IDLE;
        default:
          hst_reg <= USH_H_IDLE;
      endcase
    end
  end

  assign link.tok_valid = (hst_reg == USH_H_TOK);
  assign link.tok_pid   = (hst_reg == USH_H_TOK) ? pid_reg :
                                                   ush_pkg::USH_TOK_NONE;
  assign link.tok_last  = (hst_reg == USH_H_TOK) &&
                          cnt_reg == 6'(ush_pkg::TOK_CYC - 1);

  // Result of the last transaction, held until the next; done is a one-cycle pulse
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      done      <= 1'b0;
      got_nak   <= 1'b0;
      byte_cnt  <= 4'h0;
      last_byte <= 8'h00;
    end
    else
    begin
      done <= (hst_reg == USH_H_WAIT || hst_reg == USH_H_RX) &&
              link.rsp_valid && link.rsp_last;
      if (hst_reg == USH_H_TOK)
      begin
        got_nak  <= 1'b0;
        byte_cnt <= 4'h0;
      end
      else if (link.rsp_valid &&
               (hst_reg == USH_H_WAIT || hst_reg == USH_H_RX))
      begin
        if (link.rsp_pid == ush_pkg::USH_RSP_NAK)
          got_nak <= 1'b1;
        else
        begin
          byte_cnt  <= byte_cnt + 4'h1;
          last_byte <= link.rsp_data;
        end
      end
    end
  end

  // Software agent: guard costs an orphaned token, so it is optional
  // guard only on request
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      sst_reg <= USH_S_IDLE;
    else
    begin
      case (sst_reg)
        USH_S_IDLE:
          if (sw_clear_req && guard_en)
            sst_reg <= USH_S_CLEAR;
        USH_S_CLEAR:
          sst_reg <= USH_S_ENABLE;
        USH_S_ENABLE:
          sst_reg <= USH_S_IDLE;
        default:
          sst_reg <= USH_S_IDLE;
      endcase
    end
  end

  assign sw_flag_clear    = (sst_reg == USH_S_CLEAR) ||
                            (sst_reg == USH_S_IDLE && sw_clear_req &&
                             !guard_en);
  assign sw_module_enable = rst_n && (sst_reg == USH_S_IDLE);

endmodule : ush_host
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct {int op; logic flag; logic nak;} ush_row_t;
  logic       clk_sys, rst_n, send_setup, send_in, sw_clear_req, guard_en;
  logic       setup_received_flag, irq, ready, done, got_nak;
  logic       sw_flag_clear, sw_module_enable, tx_busy;
  logic [3:0] byte_cnt;
  logic [7:0] in_data, last_byte;
  int         mismatches, n_checks, cyc, i;
  // Ops: 0 SETUP, 1 IN, 2 plain clear, 3 guarded clear
  ush_row_t   rows[8] = '{'{0, 1, 0}, '{1, 1, 1}, '{1, 1, 1}, '{2, 0, 0},
                          '{1, 0, 0}, '{0, 1, 0}, '{3, 0, 0}, '{1, 0, 0}};

  ush_link_if ush_link_if_i ();
  ush_dev ush_dev_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(ush_link_if_i),
    .bus_module_enable(sw_module_enable), .flag_clear(sw_flag_clear),
    .in_data(in_data), .setup_received_flag(setup_received_flag),
    .irq(irq), .tx_busy(tx_busy));
  ush_host ush_host_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(ush_link_if_i), .send_setup(send_setup), .send_in(send_in),
    .ready(ready), .done(done), .got_nak(got_nak), .byte_cnt(byte_cnt),
    .last_byte(last_byte), .sw_clear_req(sw_clear_req),
    .guard_en(guard_en), .sw_flag_clear(sw_flag_clear),
    .sw_module_enable(sw_module_enable));
  ush_link_assertions ush_link_assertions_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .tok_valid(ush_link_if_i.tok_valid),
    .tok_pid(ush_link_if_i.tok_pid), .tok_last(ush_link_if_i.tok_last),
    .rsp_valid(ush_link_if_i.rsp_valid), .rsp_pid(ush_link_if_i.rsp_pid),
    .rsp_last(ush_link_if_i.rsp_last));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic tick(int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Clear mid-CRC lands inside the second CRC bit of the IN token
  task automatic op(int k);
    int n;
    n = 0;
    while (ready !== 1'b1) tick(1);
    if (k < 2 || k == 4)
    begin
      send_setup = (k == 0);
      send_in    = (k != 0);
      tick(1);
      send_setup = 1'b0;
      send_in    = 1'b0;
      if (k == 4)
      begin
        while (ush_link_if_i.tok_valid !== 1'b1) tick(1);
        tick(ush_pkg::TOK_HDR_CYC + ush_pkg::CRC_BIT_CYC);
        sw_clear_req = 1'b1;
        tick(1);
        sw_clear_req = 1'b0;
      end
      while (n < 100 && ((k == 0) ? setup_received_flag : done) !== 1'b1)
      begin
        tick(1);
        n++;
      end
      chk("answer_done", 8'h01, {7'h00, n < 100});
    end
    else
    begin
      guard_en     = (k == 3);
      sw_clear_req = 1'b1;
      tick(1);
      chk("module_enable", {7'h00, k != 3}, {7'h00, sw_module_enable});
      sw_clear_req = 1'b0;
      tick(4);
    end
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    {send_setup, send_in, sw_clear_req, guard_en} = 4'h0;
    in_data = 8'ha5;
    rst_n   = 1'b0;
    tick(10);
    chk("flag", 8'h00, {7'h00, setup_received_flag});
    chk("ready", 8'h01, {7'h00, ready});
    rst_n = 1'b1;
    foreach (rows[j])
    begin
      op(rows[j].op);
      chk("flag", {7'h00, rows[j].flag}, {7'h00, setup_received_flag});
      chk("irq", {7'h00, rows[j].flag}, {7'h00, irq});
      if (rows[j].op == 1)
      begin
        chk("got_nak", {7'h00, rows[j].nak}, {7'h00, got_nak});
        if (!rows[j].nak)
        begin
          chk("byte_cnt", 8'h08, {4'h0, byte_cnt});
          chk("last_byte", in_data, last_byte);
        end
      end
    end
    // Awkward: clear within the token CRC, plain and then guarded
    for (i = 0; i < 2; i++)
    begin
      guard_en = (i == 1);
      op(0);
      op(4);
      chk("got_nak", 8'h00, {7'h00, got_nak});
      chk("byte_cnt", 8'h08, {4'h0, byte_cnt});
      chk("flag", 8'h00, {7'h00, setup_received_flag});
    end
    // Reset in mid data packet must silence the transmitter
    send_in = 1'b1;
    tick(1);
    send_in = 1'b0;
    tick(ush_pkg::TOK_CYC + 3);
    chk("tx_busy", 8'h01, {7'h00, tx_busy});
    rst_n = 1'b0;
    tick(2);
    chk("rsp_valid", 8'h00, {7'h00, ush_link_if_i.rsp_valid});
    chk("tx_busy", 8'h00, {7'h00, tx_busy});
    rst_n = 1'b1;
    tick(2);
    chk("ready", 8'h01, {7'h00, ready});
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire

//--- testbench/ush_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ush_link_assertions
(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              tok_valid,
  input wire ush_pkg::ush_tok_t tok_pid,
  input wire logic              tok_last,
  input wire logic              rsp_valid,
  input wire ush_pkg::ush_rsp_t rsp_pid,
  input wire logic              rsp_last
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_data_body;
    (rsp_valid && !rsp_last)[*7] ##1 (rsp_valid && rsp_last);
  endsequence
  property p_ask;
    $rose(rsp_valid) |->
      $past(tok_last) && $past(tok_pid) == ush_pkg::USH_TOK_IN;
  endproperty
  a_ask: assert property (p_ask)
    else $error("answer without IN token");
  property p_setup_mute;
    tok_last && tok_pid == ush_pkg::USH_TOK_SETUP |=> !rsp_valid[*2];
  endproperty
  a_setup_mute: assert property (p_setup_mute)
    else $error("answer to SETUP");
  property p_nak;
    rsp_valid && rsp_pid == ush_pkg::USH_RSP_NAK |-> rsp_last ##1 !rsp_valid;
  endproperty
  a_nak: assert property (p_nak)
    else $error("NAK not single cycle");
  property p_data;
    $rose(rsp_valid) && rsp_pid == ush_pkg::USH_RSP_DATA |-> s_data_body;
  endproperty
  a_data: assert property (p_data)
    else $error("data packet length wrong");
  property p_end;
    rsp_last |=> !rsp_valid;
  endproperty
  a_end: assert property (p_end)
    else $error("transmit after last cycle");
  property p_quiet;
    tok_valid |-> !rsp_valid;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("transmit during token");
  property p_rsp_kind;
    $rose(rsp_valid) |->
      rsp_pid inside {ush_pkg::USH_RSP_NAK, ush_pkg::USH_RSP_DATA};
  endproperty
  a_rsp_kind: assert property (p_rsp_kind)
    else $error("answer kind invalid");
  property p_tok_hold;
    tok_valid && !tok_last |=> tok_valid && $stable(tok_pid);
  endproperty
  a_tok_hold: assert property (p_tok_hold)
    else $error("token broken off");
endmodule // ush_link_assertions
`default_nettype wire
